// ==== logic/rts_pkg.sv ====
// package for the reset time-out sequencer: register map, timing, enums
package rts_pkg;
  // bus register byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0; // power_reset_status
  localparam logic [3:0] ADDR_CAUSE = 4'h4; // reset cause, flags and state
  localparam logic [3:0] ADDR_PC = 4'h8; // program counter start value
  localparam logic [3:0] ADDR_CONFIG = 4'hC; // configuration fuses
  // power_reset_status fields
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON = 1;
  // config fields
  localparam int BIT_POWERUP_DELAY_TIMER_EN_N = 0;
  localparam int BIT_BO_EN = 1;
  localparam int BIT_MODE_LO = 2;
  localparam logic [3:0] CONFIG_RESET = 4'h0; // delay enabled, brown-out off, rc mode
  // vectors
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
  // timing, clock at 25 MHz
  localparam longint CLK_HZ = 25000000;
  localparam longint POWERUP_DELAY_US = 72000; // 72 ms
  localparam longint POWERUP_DELAY_CYC = POWERUP_DELAY_US * CLK_HZ / 1000000;
  localparam longint BROWNOUT_MIN_NS = 100000; // 100 us
  localparam longint BROWNOUT_MIN_CYC = (BROWNOUT_MIN_NS * CLK_HZ + 999999999) / 1000000000;
  localparam logic [10:0] OSC_SETTLE_COUNT = 11'h400; // 1024 oscillator cycles
  localparam int DELAY_W = 32;

  typedef enum logic [1:0] {
    RTS_RESISTOR_CAPACITOR_MODE = 2'h0,
    RTS_LOW_POWER_CRYSTAL_MODE = 2'h1,
    RTS_CRYSTAL_MODE = 2'h2,
    RTS_HIGH_SPEED_CRYSTAL_MODE = 2'h3
  } rts_osc_mode_t;

  typedef enum logic [2:0] {
    RTS_ST_RUN = 3'h0,
    RTS_ST_BROWNOUT = 3'h1,
    RTS_ST_DELAY = 3'h2,
    RTS_ST_SETTLE = 3'h3,
    RTS_ST_HOLD = 3'h4,
    RTS_ST_SLEEP = 3'h5
  } rts_state_t;

  typedef enum logic [2:0] {
    RTS_CAUSE_POWERON = 3'h0,
    RTS_CAUSE_BROWNOUT = 3'h1,
    RTS_CAUSE_MASTER_CLEAR_PIN_RUN = 3'h2,
    RTS_CAUSE_MASTER_CLEAR_PIN_SLEEP = 3'h3,
    RTS_CAUSE_WDT_RESET = 3'h4,
    RTS_CAUSE_WDT_WAKE = 3'h5,
    RTS_CAUSE_IRQ_WAKE = 3'h6
  } rts_cause_t;

  // watchdog and wake events from the core
  typedef struct packed {
    logic watchdog_timeout;
    logic irq_wake;
    logic global_irq_enable;
    logic sleep_enter;
  } rts_core_evt_t;

  // avalon request
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } rts_av_req_t;
endpackage : rts_pkg

// ==== logic/rts_down_counter.sv ====
// loadable down counter with a done level
`timescale 1ns/100ps
module rts_down_counter
  import rts_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic step,
  output logic done
);
  logic [W-1:0] count_q;

  // load wins over step so a restart is never missed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_value;
    end else if (step && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign done = (count_q == '0) && !load;
endmodule : rts_down_counter

// ==== logic/rts_sequencer.sv ====
// reset time-out sequencer: delay timer, oscillator settle count, brown-out, cause flags
`timescale 1ns/100ps
module rts_sequencer
  import rts_pkg::*;
#(
  parameter longint POWERUP_DELAY_CYCLES = POWERUP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_clear_pin_n,
  input wire logic supply_low,
  input wire logic osc_input_pin,
  input wire rts_core_evt_t core_evt,
  input wire logic [12:0] core_pc,
  input wire rts_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  output logic chip_reset,
  output logic core_wake,
  output logic [12:0] pc_load_value,
  output logic pc_load,
  output logic regs_reset,
  output logic watchdog_expiry_flag,
  output logic powerdown_flag
);
  rts_state_t state_q;
  logic [3:0] config_q;
  logic [1:0] power_reset_status_q;
  rts_cause_t cause_q;
  logic first_q;
  logic osc_prev_q;
  logic [10:0] settle_q;
  logic [11:0] low_cnt_q;
  logic wr_take;
  logic delay_load;
  logic delay_done;
  logic brownout_hit;
  logic delay_enabled;
  logic settle_applies;
  logic osc_rise;
  logic access;
  logic [31:0] rd_d;
  rts_osc_mode_t mode;

  assign mode = rts_osc_mode_t'(config_q[BIT_MODE_LO +: 2]);
  // brown-out forces the delay on whatever the active-low fuse says
  assign delay_enabled = config_q[BIT_BO_EN] || !config_q[BIT_POWERUP_DELAY_TIMER_EN_N];
  assign settle_applies = (mode != RTS_RESISTOR_CAPACITOR_MODE);
  assign osc_rise = osc_input_pin && !osc_prev_q;
  assign access = av_req.read || av_req.write;
  // a write lands only at the edge that completes the access, never during the wait cycle
  assign wr_take = av_req.write && !av_waitrequest;

  // delay counter, reloaded on every entry to brown-out or power-on
  assign delay_load = first_q || (state_q == RTS_ST_BROWNOUT);
  rts_down_counter #(.W(DELAY_W)) u_delay (
    .clk(clk),
    .reset_n(reset_n),
    .load(delay_load),
    .load_value(DELAY_W'(POWERUP_DELAY_CYCLES)),
    .step(state_q == RTS_ST_DELAY),
    .done(delay_done)
  );

  // supply-low must persist past the minimum before it counts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_q <= '0;
    end else if (!supply_low || !config_q[BIT_BO_EN]) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != 12'(BROWNOUT_MIN_CYC)) begin
      low_cnt_q <= low_cnt_q + 12'h001;
    end
  end
  assign brownout_hit = (low_cnt_q == 12'(BROWNOUT_MIN_CYC));

  // oscillator edge detect, input taken as synchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_input_pin;
    end
  end

  // settle count of oscillator input edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q <= '0;
    end else if (state_q != RTS_ST_SETTLE) begin
      settle_q <= '0;
    end else if (osc_rise) begin
      settle_q <= settle_q + 11'h001;
    end
  end

  // first cycle after reset marks the power-on event
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // configuration fuses, software writable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= CONFIG_RESET;
    end else if (wr_take && av_req.address == ADDR_CONFIG) begin
      config_q <= av_req.writedata[3:0];
    end
  end

  // main sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RTS_ST_DELAY;
    end else if (first_q) begin
      state_q <= RTS_ST_DELAY;
    end else if (brownout_hit) begin
      state_q <= RTS_ST_BROWNOUT;
    end else begin
      unique case (state_q)
        RTS_ST_BROWNOUT: begin
          if (!supply_low) state_q <= RTS_ST_DELAY;
        end
        RTS_ST_DELAY: begin
          if (delay_done || !delay_enabled) begin
            if (settle_applies && (cause_q == RTS_CAUSE_POWERON || cause_q == RTS_CAUSE_BROWNOUT))
              state_q <= RTS_ST_SETTLE;
            else state_q <= RTS_ST_HOLD;
          end
        end
        RTS_ST_SETTLE: begin
          if (settle_q == OSC_SETTLE_COUNT) state_q <= RTS_ST_HOLD;
        end
        RTS_ST_HOLD: begin
          if (master_clear_pin_n) state_q <= RTS_ST_RUN;
        end
        RTS_ST_RUN: begin
          if (!master_clear_pin_n || core_evt.watchdog_timeout) state_q <= RTS_ST_HOLD;
          else if (core_evt.sleep_enter) state_q <= RTS_ST_SLEEP;
        end
        RTS_ST_SLEEP: begin
          if (!master_clear_pin_n) state_q <= RTS_ST_HOLD;
          else if (core_evt.watchdog_timeout || core_evt.irq_wake) begin
            if (settle_applies) state_q <= RTS_ST_SETTLE;
            else state_q <= RTS_ST_RUN;
          end
        end
        default: state_q <= RTS_ST_BROWNOUT;
      endcase
    end
  end

  // reset cause and status flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= RTS_CAUSE_POWERON;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (first_q) begin
      cause_q <= RTS_CAUSE_POWERON;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (brownout_hit && state_q != RTS_ST_BROWNOUT) begin
      cause_q <= RTS_CAUSE_BROWNOUT;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (state_q == RTS_ST_RUN && !master_clear_pin_n) begin
      cause_q <= RTS_CAUSE_MASTER_CLEAR_PIN_RUN; // flags unchanged
    end else if (state_q == RTS_ST_RUN && core_evt.watchdog_timeout) begin
      cause_q <= RTS_CAUSE_WDT_RESET;
      watchdog_expiry_flag <= 1'b0;
      powerdown_flag <= 1'b1;
    end else if (state_q == RTS_ST_SLEEP && !master_clear_pin_n) begin
      cause_q <= RTS_CAUSE_MASTER_CLEAR_PIN_SLEEP;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (state_q == RTS_ST_SLEEP && core_evt.watchdog_timeout) begin
      cause_q <= RTS_CAUSE_WDT_WAKE;
      watchdog_expiry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (state_q == RTS_ST_SLEEP && core_evt.irq_wake) begin
      cause_q <= RTS_CAUSE_IRQ_WAKE;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  // status bits: hardware clear wins over a software set in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_reset_status_q <= 2'h0;
    end else begin
      if (first_q) begin
        power_reset_status_q[BIT_POWERON] <= 1'b0;
      end else if (wr_take && av_req.address == ADDR_STATUS) begin
        power_reset_status_q[BIT_POWERON] <= av_req.writedata[BIT_POWERON];
      end
      // brown-out bit is left as software wrote it when the circuit is off
      if (brownout_hit) begin
        power_reset_status_q[BIT_BROWNOUT] <= 1'b0;
      end else if (wr_take && av_req.address == ADDR_STATUS) begin
        power_reset_status_q[BIT_BROWNOUT] <= av_req.writedata[BIT_BROWNOUT];
      end
    end
  end

  // outputs toward the core, registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_reset <= 1'b1;
      core_wake <= 1'b0;
      regs_reset <= 1'b1;
      pc_load <= 1'b0;
      pc_load_value <= PC_RESET;
    end else begin
      chip_reset <= (state_q != RTS_ST_RUN) && (state_q != RTS_ST_SLEEP);
      // a wake in rc mode resumes without touching the register file; a crystal-mode wake ends in hold, which raises regs_reset
      regs_reset <= (state_q == RTS_ST_HOLD) || (state_q == RTS_ST_BROWNOUT) ||
                    ((state_q == RTS_ST_DELAY) || (state_q == RTS_ST_SETTLE &&
                    cause_q != RTS_CAUSE_WDT_WAKE && cause_q != RTS_CAUSE_IRQ_WAKE));
      core_wake <= 1'b0;
      pc_load <= 1'b0;
      if (state_q == RTS_ST_HOLD && master_clear_pin_n) begin
        pc_load <= 1'b1;
        pc_load_value <= PC_RESET;
      end else if ((state_q == RTS_ST_SETTLE && settle_q == OSC_SETTLE_COUNT &&
                    (cause_q == RTS_CAUSE_WDT_WAKE || cause_q == RTS_CAUSE_IRQ_WAKE)) ||
                   (state_q == RTS_ST_SLEEP && !settle_applies && master_clear_pin_n &&
                    (core_evt.watchdog_timeout || core_evt.irq_wake))) begin
        core_wake <= 1'b1;
        pc_load <= 1'b1;
        if (core_evt.irq_wake && core_evt.global_irq_enable) pc_load_value <= PC_IRQ_VECTOR;
        else pc_load_value <= core_pc + 13'h0001;
      end
    end
  end

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (av_req.address)
      ADDR_STATUS: rd_d = {30'h0, power_reset_status_q};
      ADDR_CAUSE: rd_d = {24'h0, state_q, cause_q, watchdog_expiry_flag, powerdown_flag};
      ADDR_PC: rd_d = {19'h0, pc_load_value};
      ADDR_CONFIG: rd_d = {28'h0, config_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // avalon slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      av_waitrequest <= 1'b1;
      av_readdata <= 32'h0000_0000;
    end else begin
      av_waitrequest <= !(access && av_waitrequest);
      if (av_req.read && av_waitrequest) av_readdata <= rd_d;
    end
  end
endmodule : rts_sequencer

// ==== bench/rts_checker.sv ====
// port checker for the reset time-out sequencer, bound to its top module
`timescale 1ns/100ps
module rts_checker
  import rts_pkg::*;
#(
  parameter longint POWERUP_DELAY_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_clear_pin_n,
  input wire rts_av_req_t av_req,
  input wire logic av_waitrequest,
  input wire logic chip_reset,
  input wire logic core_wake,
  input wire logic [12:0] pc_load_value,
  input wire logic pc_load,
  input wire logic watchdog_expiry_flag,
  input wire logic powerdown_flag
);
  logic [31:0] since_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since release; saturates so it never wraps back into the delay window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_q <= 32'h0;
    end else if (since_q != 32'hFFFFFFFF) begin
      since_q <= since_q + 32'h1;
    end
  end
  // steps of an access and of a release from reset
  sequence s_answer;
    $fell(av_waitrequest);
  endsequence
  sequence s_release;
    $fell(chip_reset);
  endsequence
  AST_WAIT_ONE: assert property (!av_waitrequest |=> av_waitrequest) else $error("waitrequest low too long");
  AST_WAIT_CAUSE: assert property (s_answer |-> $past(av_req.read || av_req.write)) else $error("answer without request");
  AST_DELAY_HOLD: assert property (since_q < POWERUP_DELAY_CYCLES - 1 |-> chip_reset)
    else $error("core left reset during the power-up delay");
  AST_FLAGS_PON: assert property (since_q < POWERUP_DELAY_CYCLES - 1 |-> watchdog_expiry_flag && powerdown_flag)
    else $error("flags not both set after power-on");
  AST_PC_PULSE: assert property (pc_load |=> !pc_load) else $error("pc load longer than one cycle");
  AST_WAKE_PULSE: assert property (core_wake |=> !core_wake) else $error("wake longer than one cycle");
  AST_RESET_PC: assert property (pc_load && watchdog_expiry_flag && powerdown_flag |-> pc_load_value == PC_RESET)
    else $error("reset start address not zero");
  AST_MASTER_CLEAR_PIN_HOLD: assert property (!master_clear_pin_n && chip_reset |=> chip_reset)
    else $error("left reset while master clear low");
  AST_RELEASE_MASTER_CLEAR_PIN: assert property (s_release |-> $past(master_clear_pin_n))
    else $error("release without master clear high");
endmodule : rts_checker

bind rts_sequencer rts_checker #(.POWERUP_DELAY_CYCLES(POWERUP_DELAY_CYCLES)) i_rts_checker (.*);

// ==== bench/rts_partner.sv ====
// far side: free-running crystal on the oscillator input and the master clear driver
`timescale 1ns/100ps
module rts_partner (
  input wire logic clk,
  input wire logic master_clear_pin_hold,
  output logic osc_input_pin,
  output logic master_clear_pin_n
);
  logic [1:0] div_q = 2'h0;
  initial master_clear_pin_n = 1'h1;
  // a crystal runs free, one period every four system clocks
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
  end
  assign osc_input_pin = div_q[1];
  // pin follows the bench just after the edge, so the design never sees a mid-cycle change
  always @(posedge clk) begin
    master_clear_pin_n <= !master_clear_pin_hold;
  end
endmodule : rts_partner

// ==== bench/testbench.sv ====
// self-checking bench for the reset time-out sequencer
`timescale 1ns/100ps
module testbench
  import rts_pkg::*;
;
  localparam longint P = 50;
  localparam int OSC_T = 4; // system clocks per oscillator period
  logic clk = 1'h0, reset_n = 1'h0, supply_low = 1'h0, master_clear_pin_hold = 1'h0;
  logic master_clear_pin_n, osc_input_pin, av_waitrequest, chip_reset, core_wake, pc_load, regs_reset;
  logic watchdog_expiry_flag, powerdown_flag;
  logic [12:0] core_pc = 13'h0, pc_load_value;
  logic [31:0] av_readdata, rd;
  rts_core_evt_t core_evt = '0;
  rts_av_req_t av_req = '0;
  int n_errors = 0, n_compared = 0, cyc = 0, t0, n;

  rts_sequencer #(.POWERUP_DELAY_CYCLES(P)) i_rts_sequencer (.*);
  rts_partner i_rts_partner (.*);

  always #20 clk = ~clk;
  // cycle count, random core pc, and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    core_pc <= 13'($urandom);
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task final_report;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon access; held until waitrequest is sampled low
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    av_req <= '{address: a, read: !w, write: w, writedata: d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (av_waitrequest !== 1'h0 && k < 100);
    rd = av_readdata;
    if (k == 100) n_errors++;
    av_req.read <= 1'h0;
    av_req.write <= 1'h0;
  endtask : bus

  task wait_run;
    n = 0;
    while (chip_reset !== 1'h0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_run

  function automatic logic [1:0] flags_of(input rts_cause_t c);
    case (c)
      RTS_CAUSE_WDT_RESET: flags_of = 2'h1;
      RTS_CAUSE_WDT_WAKE: flags_of = 2'h0;
      RTS_CAUSE_MASTER_CLEAR_PIN_SLEEP, RTS_CAUSE_IRQ_WAKE: flags_of = 2'h2;
      default: flags_of = 2'h3;
    endcase
  endfunction : flags_of

  function automatic logic [31:0] cfg_word(input rts_osc_mode_t m, input logic bo, input logic dly_n);
    cfg_word = 32'h0;
    cfg_word[BIT_MODE_LO +: 2] = m;
    cfg_word[BIT_BO_EN] = bo;
    cfg_word[BIT_POWERUP_DELAY_TIMER_EN_N] = dly_n;
  endfunction : cfg_word

  // main sequence: power-on, brown-out in crystal mode, watchdog reset, held master clear
  initial begin
    n = $urandom(47);
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    t0 = cyc;
    bus(ADDR_CONFIG, 1'h0, 32'h0);
    chk(rd[3:0], CONFIG_RESET);
    bus(ADDR_STATUS, 1'h0, 32'h0);
    chk(rd[BIT_POWERON], 1'h0);
    bus(ADDR_CAUSE, 1'h0, 32'h0);
    chk(rd[1:0], flags_of(RTS_CAUSE_POWERON));
    bus(4'h6, 1'h1, $urandom);
    bus(4'h6, 1'h0, 32'h0);
    chk(rd, 32'h0);
    wait_run;
    chk(cyc - t0 >= P && cyc - t0 <= P + 12, 1'h1);
    chk(pc_load_value, PC_RESET);
    chk(regs_reset, 1'h0);
    bus(ADDR_STATUS, 1'h1, ($urandom & 32'hFFFFFFFC) | 32'h3);
    bus(ADDR_STATUS, 1'h0, 32'h0);
    chk(rd[1:0], 2'h3);
    // delay fuse off: the brown-out enable must still force the delay
    bus(ADDR_CONFIG, 1'h1, cfg_word(RTS_CRYSTAL_MODE, 1'h1, 1'h1));
    supply_low <= 1'h1;
    repeat (2600) @(posedge clk);
    chk(chip_reset, 1'h1);
    supply_low <= 1'h0;
    repeat (20) @(posedge clk);
    chk(chip_reset, 1'h1);
    supply_low <= 1'h1;
    repeat (2600) @(posedge clk);
    supply_low <= 1'h0;
    t0 = cyc;
    wait_run;
    chk(cyc - t0 >= P + OSC_T * 1024 - 8 && cyc - t0 <= P + OSC_T * 1024 + 40, 1'h1);
    bus(ADDR_STATUS, 1'h0, 32'h0);
    chk(rd[1:0], 2'h2);
    bus(ADDR_CAUSE, 1'h0, 32'h0);
    chk(rd[1:0], flags_of(RTS_CAUSE_BROWNOUT));
    // watchdog reset while running: no settle count applies
    core_evt.watchdog_timeout <= 1'h1;
    @(posedge clk);
    core_evt.watchdog_timeout <= 1'h0;
    repeat (3) @(posedge clk);
    wait_run;
    chk(n <= 8, 1'h1);
    chk({watchdog_expiry_flag, powerdown_flag}, flags_of(RTS_CAUSE_WDT_RESET));
    chk(pc_load_value, PC_RESET);
    // master clear held low past all time-outs, then let go
    master_clear_pin_hold <= 1'h1;
    reset_n <= 1'h0;
    @(posedge clk);
    reset_n <= 1'h1;
    repeat (P + 100) @(posedge clk);
    chk(chip_reset, 1'h1);
    chk(regs_reset, 1'h1);
    master_clear_pin_hold <= 1'h0;
    wait_run;
    chk(n <= 8, 1'h1);
    // sleep, then an enabled interrupt wakes the core in rc mode with no settle count
    core_evt.sleep_enter <= 1'h1;
    @(posedge clk);
    core_evt <= '{watchdog_timeout: 1'h0, irq_wake: 1'h1, global_irq_enable: 1'h1, sleep_enter: 1'h0};
    @(posedge clk);
    core_evt <= '0;
    repeat (3) @(posedge clk);
    chk(pc_load_value, PC_IRQ_VECTOR);
    chk({watchdog_expiry_flag, powerdown_flag}, flags_of(RTS_CAUSE_IRQ_WAKE));
    chk(regs_reset, 1'h0);
    chk(chip_reset, 1'h0);
    final_report();
  end
endmodule : testbench
